// ==== hdl/dbgsr_top.sv ====
// Purpose: wait/stop and access-failure status, hardware breakpoint pair, host forced reset
// Assumes: serial decoder hands over decoded commands on i_clk; cpu signals are synchronous
// Notes: user-program writes arrive on a separate strobe and are dropped for the debug registers
`include "dbgsr_defs.svh"
module dbgsr_top #(
  parameter int ADDR_W = 16
) (
  // clock, reset, enable
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_ce,
  // serial command decoder
  input  wire logic              i_cmd_wr,
  input  wire logic              i_cmd_rd,
  input  wire logic [7:0]        i_cmd_addr,
  input  wire logic [7:0]        i_cmd_wdata,
  input  wire logic              i_cmd_bkpt_wr,
  input  wire logic [15:0]       i_cmd_bkpt_wdata,
  input  wire logic              i_cmd_bkpt_rd,
  input  wire logic              i_cmd_halt,
  input  wire logic              i_mem_cmd_done,
  input  wire logic              i_mem_cmd_sleep_conflict,
  input  wire logic              i_mem_cmd_slow_conflict,
  input  wire logic              i_cmd_status_clr,
  // user program write attempts
  input  wire logic              i_user_wr,
  input  wire logic [7:0]        i_user_addr,
  input  wire logic [7:0]        i_user_wdata,
  // cpu side
  input  wire logic              i_cpu_sleep,
  input  wire logic              i_debug_active,
  input  wire logic [ADDR_W-1:0] i_cpu_addr,
  input  wire logic              i_cpu_fetch,
  input  wire logic              i_cpu_exec_tagged,
  input  wire logic              i_insn_boundary,
  // outputs
  output logic [7:0]             o_rdata,
  output logic [15:0]            o_bkpt_rdata,
  output logic                   o_break_req,
  output logic                   o_tag_opcode,
  output logic                   o_wake_to_debug,
  output logic                   o_force_reset
);
  logic rst_s1;
  logic rst_s2;
  logic rst_b;

  // reset released through two flops so release is clean against i_clk
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  assign rst_b = rst_s2;

  logic [7:0] bkpt_high;
  logic [7:0] bkpt_low;
  logic       brk_en;
  logic       force_or_tag_select;
  logic       halted_from_sleep;
  logic       sleep_conflict_fail_flag;
  logic       slow_access_fail_flag;
  logic       force_pend;
  logic [3:0] rst_cnt;
  dbgsr_pkg::dbgsr_rst_state_t rst_state;
  logic [7:0] rdata;
  logic [15:0] bkpt_rdata;
  logic       break_req;
  logic       tag_opcode;
  logic       force_hit;

  logic [7:0] next_bkpt_high;
  logic [7:0] next_bkpt_low;
  logic       next_brk_en;
  logic       next_fts;
  logic       next_halted_from_sleep;
  logic       next_wsf;
  logic       next_dvf;
  logic       next_force_pend;
  logic [3:0] next_rst_cnt;
  dbgsr_pkg::dbgsr_rst_state_t next_rst_state;
  logic [7:0] next_rdata;
  logic [15:0] next_bkpt_rdata;
  logic       next_break_req;
  logic       next_tag_opcode;
  logic       next_force_hit;
  logic       sleeping_flag;
  logic       addr_match;
  logic [7:0] status_byte;

  // the sleeping flag stays up after a halt pulled the cpu out of wait/stop
  assign sleeping_flag = i_cpu_sleep | halted_from_sleep; // RULE1
  // comparator sees the whole bus; enable gates everything downstream
  assign addr_match = brk_en && (i_cpu_addr == ADDR_W'({bkpt_high, bkpt_low})); // RULE17 RULE14

  always_comb begin
    status_byte = 8'h00;
    status_byte[`DBGSR_BIT_DVF]    = slow_access_fail_flag;
    status_byte[`DBGSR_BIT_WSF]    = sleep_conflict_fail_flag;
    status_byte[`DBGSR_BIT_SLEEP]  = sleeping_flag;
    status_byte[`DBGSR_BIT_FTS]    = force_or_tag_select;
    status_byte[`DBGSR_BIT_BREAK_ENABLE_BIT] = brk_en;
    status_byte[`DBGSR_BIT_ACTIVE] = i_debug_active;
  end

  // register and status next values; user writes never reach this path
  always_comb begin
    next_bkpt_high         = bkpt_high;
    next_bkpt_low          = bkpt_low;
    next_brk_en            = brk_en;
    next_fts               = force_or_tag_select;
    next_halted_from_sleep = halted_from_sleep;
    next_wsf               = sleep_conflict_fail_flag;
    next_dvf               = slow_access_fail_flag;
    next_force_pend        = 1'b0;
    next_rdata             = rdata;
    next_bkpt_rdata        = bkpt_rdata;
    // breakpoint commands are foreground: no active-debug check here
    if (i_cmd_bkpt_wr) begin // RULE7 RULE8
      next_bkpt_high = i_cmd_bkpt_wdata[15:8]; // RULE5
      next_bkpt_low  = i_cmd_bkpt_wdata[7:0];
    end
    if (i_cmd_bkpt_rd) begin // RULE7 RULE8
      next_bkpt_rdata = {bkpt_high, bkpt_low};
    end
    if (i_cmd_wr && i_debug_active) begin
      if (i_cmd_addr == `DBGSR_OFS_STATUS) begin // RULE6
        next_brk_en = i_cmd_wdata[`DBGSR_BIT_BREAK_ENABLE_BIT];
        next_fts    = i_cmd_wdata[`DBGSR_BIT_FTS];
      end
      if (i_cmd_addr == `DBGSR_OFS_FORCE_RESET) begin // RULE10
        next_force_pend = i_cmd_wdata[`DBGSR_BIT_FRST]; // RULE13
      end
    end
    if (i_cmd_rd) begin
      if (i_cmd_addr == `DBGSR_OFS_STATUS) begin
        next_rdata = status_byte;
      end else begin
        next_rdata = `DBGSR_RST_BYTE; // RULE11 RULE12
      end
    end
    // failure flags: set wins over clear
    if (i_cmd_status_clr) begin
      next_wsf = 1'b0;
      next_dvf = 1'b0;
    end
    if (i_mem_cmd_done && i_mem_cmd_sleep_conflict) begin
      next_wsf = 1'b1; // RULE2
    end
    if (i_mem_cmd_done && i_mem_cmd_slow_conflict) begin
      next_dvf = 1'b1; // RULE3
    end
    // remember that debug was entered from wait/stop until debug is left
    if (i_cmd_halt && i_cpu_sleep) begin
      next_halted_from_sleep = 1'b1; // RULE16 RULE1
    end else if (!i_debug_active && !i_cmd_halt) begin
      next_halted_from_sleep = 1'b0;
    end
  end

  // breakpoint action: force waits for boundary, tag waits for execution
  always_comb begin
    next_force_hit  = force_hit;
    next_break_req  = 1'b0;
    next_tag_opcode = 1'b0;
    if (!brk_en) begin
      next_force_hit = 1'b0; // RULE14
    end else if (force_or_tag_select) begin
      if (addr_match) begin
        next_force_hit = 1'b1; // RULE15
      end
      if ((force_hit || addr_match) && i_insn_boundary) begin
        next_break_req = 1'b1; // RULE15 RULE6
        next_force_hit = 1'b0;
      end
    end else begin
      next_force_hit  = 1'b0;
      next_tag_opcode = addr_match && i_cpu_fetch; // RULE15
      next_break_req  = i_cpu_exec_tagged; // RULE15
    end
  end

  // forced reset pulse; held several cycles so the reset tree sees it
  always_comb begin
    next_rst_state = rst_state;
    next_rst_cnt   = rst_cnt;
    case (rst_state)
      dbgsr_pkg::DBGSR_ST_IDLE: begin
        if (force_pend) begin // RULE13
          next_rst_state = dbgsr_pkg::DBGSR_ST_RESET;
          next_rst_cnt   = `DBGSR_RST_PULSE_CYC;
        end
      end
      dbgsr_pkg::DBGSR_ST_RESET: begin
        next_rst_cnt = rst_cnt - 4'h1;
        if (rst_cnt == 4'h1) begin
          next_rst_state = dbgsr_pkg::DBGSR_ST_IDLE;
        end
      end
      default: begin
        next_rst_state = dbgsr_pkg::DBGSR_ST_IDLE;
      end
    endcase
  end

  // state registers; clock enable freezes everything
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      bkpt_high         <= `DBGSR_RST_BYTE;
      bkpt_low          <= `DBGSR_RST_BYTE;
      brk_en            <= 1'b0;
      force_or_tag_select               <= 1'b0;
      halted_from_sleep <= 1'b0;
      sleep_conflict_fail_flag               <= 1'b0;
      slow_access_fail_flag               <= 1'b0;
      force_pend        <= 1'b0;
      rst_cnt           <= 4'h0;
      rst_state         <= dbgsr_pkg::DBGSR_ST_IDLE;
      rdata             <= `DBGSR_RST_BYTE;
      bkpt_rdata        <= 16'h0000;
      break_req         <= 1'b0;
      tag_opcode        <= 1'b0;
      force_hit         <= 1'b0;
    end else if (i_ce) begin
      bkpt_high         <= next_bkpt_high;
      bkpt_low          <= next_bkpt_low;
      brk_en            <= next_brk_en;
      force_or_tag_select               <= next_fts;
      halted_from_sleep <= next_halted_from_sleep;
      sleep_conflict_fail_flag               <= next_wsf;
      slow_access_fail_flag               <= next_dvf;
      force_pend        <= next_force_pend;
      rst_cnt           <= next_rst_cnt;
      rst_state         <= next_rst_state;
      rdata             <= next_rdata;
      bkpt_rdata        <= next_bkpt_rdata;
      break_req         <= next_break_req;
      tag_opcode        <= next_tag_opcode;
      force_hit         <= next_force_hit;
    end
  end

  assign o_rdata         = rdata;
  assign o_bkpt_rdata    = bkpt_rdata;
  assign o_break_req     = break_req;
  assign o_tag_opcode    = tag_opcode;
  assign o_wake_to_debug = i_cmd_halt & i_cpu_sleep; // RULE16
  assign o_force_reset   = (rst_state == dbgsr_pkg::DBGSR_ST_RESET);

  // user writes are accepted on the port and deliberately discarded
  logic unused_user;
  assign unused_user = i_user_wr ^ (^i_user_addr) ^ (^i_user_wdata);
endmodule

// ==== hdl/dbgsr_defs.svh ====
// Purpose: constants for the debug status, breakpoint and force-reset block
// Assumes: 8-bit registers, 16-bit cpu address bus
// Notes: offsets are register indices inside the debug controller space
// Notes on behaviour
// (RULE1) sleeping flag: cpu in wait/stop, or halted from it
// (RULE2) sleep conflict fail flag at bit 1
// (RULE3) slow access fail flag at bit 0
// (RULE4) host recovers: halt, retry, resume user program
// (RULE5) breakpoint address kept as high/low byte pair
// (RULE6) enable and force/tag bits govern breakpoint use
// (RULE7) pair reachable only by breakpoint serial commands
// (RULE8) breakpoint commands work while user program runs
// (RULE9) host sets breakpoint during active debug
// (RULE10) force reset written only by serial active-debug command
// (RULE11) force reset register always reads zero
// (RULE12) force reset bits seven to one reserved zero
// (RULE13) writing one to bit zero forces reset
// (RULE14) enable clear ignores select and address
// (RULE15) force breaks at boundary, tag breaks at execute
// (RULE16) halt command pulls cpu out of wait/stop
// (RULE17) full address equals pair while enabled
`ifndef DBGSR_DEFS_SVH
`define DBGSR_DEFS_SVH
`define DBGSR_OFS_BKPT_HIGH   8'h01
`define DBGSR_OFS_BKPT_LOW    8'h02
`define DBGSR_OFS_FORCE_RESET 8'h03
`define DBGSR_OFS_STATUS      8'h04
`define DBGSR_BIT_DVF         0
`define DBGSR_BIT_WSF         1
`define DBGSR_BIT_SLEEP       2
`define DBGSR_BIT_FTS         3
`define DBGSR_BIT_BREAK_ENABLE_BIT      4
`define DBGSR_BIT_ACTIVE      6
`define DBGSR_BIT_FRST        0
`define DBGSR_RST_BYTE        8'h00
`define DBGSR_RST_PULSE_CYC   4'h8
`endif

// ==== hdl/dbgsr_pkg.sv ====
// Purpose: types for the debug status, breakpoint and force-reset block
// Assumes: nothing beyond the defines header
// Notes: idle and reset states of the forced reset sequencer
package dbgsr_pkg;
  typedef enum logic [1:0] {
    DBGSR_ST_IDLE,
    DBGSR_ST_RESET
  } dbgsr_rst_state_t;
endpackage

// ==== testbench/dbgsr_top_properties.sv ====
// Purpose: port-level checks on the debug status, breakpoint and force-reset block
// Assumes: checks are paused while i_ce is low, since frozen state takes no strobe
// Notes: the reset copy lags two edges; nothing is requested that early
module dbgsr_chk (
  input wire logic        i_clk, i_rst_b, i_ce, i_cmd_wr, i_cmd_rd, i_cmd_bkpt_wr, i_cmd_bkpt_rd, i_cmd_halt,
  input wire logic        i_mem_cmd_done, i_mem_cmd_sleep_conflict, i_mem_cmd_slow_conflict, i_cpu_sleep,
  input wire logic        i_debug_active, i_cpu_fetch, i_cpu_exec_tagged, i_insn_boundary,
  input wire logic [7:0]  i_cmd_addr, o_rdata,
  input wire logic [15:0] i_cmd_bkpt_wdata, o_bkpt_rdata,
  input wire logic        o_break_req, o_tag_opcode, o_wake_to_debug, o_force_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b || !i_ce);
  // status byte read at index 4
  wire st_rd = i_cmd_rd && i_cmd_addr == 8'h04;
  // wake is combinational, so it must agree in every cycle
  AST_WAKE: assert property (o_wake_to_debug == (i_cmd_halt && i_cpu_sleep))
    else $error("wake out of step with halt");
  AST_FRST_LEN: assert property ($rose(o_force_reset) |-> o_force_reset [*8] ##1 !o_force_reset)
    else $error("forced reset pulse length wrong");
  AST_FRST_SRC: assert property ($rose(o_force_reset) |-> $past(i_cmd_wr && i_debug_active, 2))
    else $error("forced reset without serial write");
  AST_RD_ZERO: assert property (i_cmd_rd && (i_cmd_addr == 8'h03 || i_cmd_addr > 8'h04) |=> o_rdata == 8'h00)
    else $error("zero read not zero");
  AST_SLEEP: assert property (st_rd && i_cpu_sleep |=> o_rdata[2] && !o_rdata[7] && !o_rdata[5])
    else $error("sleeping flag wrong");
  AST_WSF: assert property ((i_mem_cmd_done && i_mem_cmd_sleep_conflict) ##1 st_rd |=> o_rdata[1])
    else $error("sleep conflict flag not set");
  AST_BKPT: assert property (i_cmd_bkpt_wr ##1 i_cmd_bkpt_rd |=> o_bkpt_rdata == $past(i_cmd_bkpt_wdata, 2))
    else $error("pair read back wrong");
  AST_TAG: assert property (o_tag_opcode |-> $past(i_cpu_fetch))
    else $error("tag without fetch");
  AST_BRK: assert property (o_break_req |-> $past(i_insn_boundary || i_cpu_exec_tagged))
    else $error("break without cause");
  // main scenarios reached
  cover property ($rose(o_force_reset));
  cover property (o_tag_opcode ##[1:6] o_break_req);
  cover property (o_wake_to_debug);
endmodule
bind dbgsr_top dbgsr_chk chk_u (.*);

// ==== testbench/dbgsr_host.sv ====
// Purpose: debug host model issuing decoded serial commands
// Assumes: tasks are entered 10 ns after a rising edge
// Notes: released lines are inverted so a stale value never passes
module dbgsr_host (
  input  wire logic   i_clk,
  output logic        o_wr, o_rd, o_bwr, o_brd, o_halt,
  output logic [7:0]  o_addr, o_wdata,
  output logic [15:0] o_bdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {o_wr, o_rd, o_bwr, o_brd, o_halt, o_addr, o_wdata, o_bdata} = '0;
  // one-cycle strobe, release, then a gap so strobes never merge
  task automatic go(ref logic s);
    s = 1'b1;
    @(posedge i_clk);
    #10;
    s = 1'b0;
    {o_addr, o_wdata, o_bdata} = ~{o_addr, o_wdata, o_bdata};
    @(posedge i_clk);
    #10;
  endtask
  task automatic wr(input logic [7:0] a, d);
    {o_addr, o_wdata} = {a, d};
    go(o_wr);
  endtask
  task automatic rd(input logic [7:0] a);
    o_addr = a;
    go(o_rd);
  endtask
  // program the pair and read it back in the very next cycle
  task automatic bwr(input logic [15:0] w);
    {o_bdata, o_bwr} = {w, 1'b1};
    @(posedge i_clk);
    #10;
    {o_bdata, o_bwr} = {~w, 1'b0};
    go(o_brd);
  endtask
  task automatic brd();
    go(o_brd);
  endtask
  task automatic hlt();
    go(o_halt);
  endtask
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the debug status, breakpoint and force-reset block
// Assumes: 10 MHz clock, inputs change 10 ns after each rising edge
// Notes: pairs are random from a fixed seed, all-zero and all-one first
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk, i_rst_b, i_ce, i_cmd_wr, i_cmd_rd, i_cmd_bkpt_wr, i_cmd_bkpt_rd, i_cmd_halt, i_user_wr;
  logic        i_mem_cmd_done, i_mem_cmd_sleep_conflict, i_mem_cmd_slow_conflict, i_cmd_status_clr;
  logic        i_cpu_sleep, i_debug_active, i_cpu_fetch, i_cpu_exec_tagged, i_insn_boundary;
  logic        o_break_req, o_tag_opcode, o_wake_to_debug, o_force_reset;
  logic [7:0]  i_cmd_addr, i_cmd_wdata, i_user_addr, i_user_wdata, o_rdata;
  logic [15:0] i_cmd_bkpt_wdata, o_bkpt_rdata, i_cpu_addr, bd, rv;
  logic [31:0] seed;
  int          n_fail, samples_checked, n_brk, n_tag, n_frst, n_wake, cyc;
  dbgsr_host h (.i_clk(i_clk), .o_wr(i_cmd_wr), .o_rd(i_cmd_rd), .o_bwr(i_cmd_bkpt_wr), .o_brd(i_cmd_bkpt_rd),
    .o_halt(i_cmd_halt), .o_addr(i_cmd_addr), .o_wdata(i_cmd_wdata), .o_bdata(i_cmd_bkpt_wdata));
  dbgsr_top dut_u (.*);
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  // expected status byte; bits 7 and 5 are always zero
  function automatic logic [7:0] st(logic a, en, force_or_tag_select, sl, wf, df);
    return {1'b0, a, 1'b0, en, force_or_tag_select, sl, wf, df};
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cy(int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask
  // random noise only on data bits that no check leans on
  task automatic uw(logic [7:0] a, d);
    logic [15:0] r;
    r = xs();
    {i_user_wr, i_user_addr, i_user_wdata} = {1'b1, a, d ^ (r[7:0] & 8'he6)};
    cy(1);
    i_user_wr = 1'b0;
  endtask
  // clear flags, end a memory command, read the status straight after
  task automatic fail(logic s, l);
    i_cmd_status_clr = 1'b1;
    cy(1);
    {i_cmd_status_clr, i_mem_cmd_done, i_mem_cmd_sleep_conflict, i_mem_cmd_slow_conflict} = {2'b01, s, l};
    cy(1);
    {i_mem_cmd_done, i_mem_cmd_sleep_conflict, i_mem_cmd_slow_conflict} = 3'b000;
    h.rd(8'h04);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // event counters and a hang limit; falling edge, so outputs have settled
  always @(negedge i_clk) begin
    cyc++;
    n_wake += (o_wake_to_debug === 1'b1);
    n_brk += (o_break_req === 1'b1);
    n_tag += (o_tag_opcode === 1'b1);
    n_frst += (o_force_reset === 1'b1);
    if (cyc == 3000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    seed = 32'hcadc;
    i_ce = 1'b1;
    {i_rst_b, i_mem_cmd_done, i_mem_cmd_sleep_conflict, i_mem_cmd_slow_conflict, i_cmd_status_clr} = '0;
    {i_user_wr, i_user_addr, i_user_wdata, i_cpu_sleep, i_debug_active, i_cpu_addr} = '0;
    {i_cpu_fetch, i_cpu_exec_tagged, i_insn_boundary} = '0;
    cy(10);
    i_rst_b = 1'b1;
    cy(3);
    // status control bits take only serial writes in active debug
    i_debug_active = 1'b1;
    h.wr(8'h04, 8'h18);
    h.rd(8'h04);
    chk("status", st(1, 1, 1, 0, 0, 0), o_rdata);
    i_debug_active = 1'b0;
    h.wr(8'h04, 8'h00);
    uw(8'h04, 8'h00);
    h.rd(8'h04);
    chk("status kept", st(0, 1, 1, 0, 0, 0), o_rdata);
    // pair through its own commands while the program runs
    for (int i = 0; i < 6; i++) begin
      bd = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : xs();
      h.bwr(bd);
      chk("pair", bd, o_bkpt_rdata);
    end
    // clock enable low: neither the write nor the read may land
    i_ce = 1'b0;
    h.bwr(~bd);
    i_ce = 1'b1;
    chk("frozen pair", bd, o_bkpt_rdata);
    i_debug_active = 1'b1;
    h.wr(8'h02, ~bd[7:0]);
    uw(8'h01, ~bd[15:8]);
    h.brd();
    chk("pair hidden", bd, o_bkpt_rdata);
    $display("test status and pair done");
    // forced reset: inactive or user writes do nothing
    i_debug_active = 1'b0;
    h.wr(8'h03, 8'h01);
    i_debug_active = 1'b1;
    uw(8'h03, 8'h01);
    cy(3);
    chk("no reset", 16'h0000, 16'(n_frst));
    h.wr(8'h03, 8'hff);
    cy(12);
    chk("reset cycles", 16'h0008, 16'(n_frst));
    h.rd(8'h03);
    chk("reset reg", 16'h0000, o_rdata);
    h.rd(8'h7f);
    chk("unmapped", 16'h0000, o_rdata);
    // failure flags, with halt and retry after a sleep conflict
    fail(1'b1, 1'b0);
    chk("sleep fail", 2'b10, o_rdata[1:0]);
    h.hlt();
    chk("no wake", 16'h0000, 16'(n_wake));
    h.rd(8'h04);
    fail(1'b0, 1'b1);
    chk("slow fail", 2'b01, o_rdata[1:0]);
    fail(1'b0, 1'b0);
    chk("no fail", 2'b00, o_rdata[1:0]);
    for (int i = 0; i < 4; i++) begin
      rv = xs();
      fail(rv[0], rv[1]);
      chk("random fail", {rv[0], rv[1]}, o_rdata[1:0]);
    end
    // halt pulls a sleeping cpu into debug; flag holds until debug ends
    {i_cpu_sleep, i_debug_active} = 2'b10;
    h.rd(8'h04);
    chk("sleeping", 1'b1, o_rdata[2]);
    // the cpu enters active debug as the halt is taken
    i_debug_active = 1'b1;
    h.hlt();
    chk("wake", 16'h0001, 16'(n_wake));
    i_cpu_sleep = 1'b0;
    h.rd(8'h04);
    chk("sleep held", 1'b1, o_rdata[2]);
    i_debug_active = 1'b0;
    cy(2);
    h.rd(8'h04);
    chk("sleep clear", 1'b0, o_rdata[2]);
    $display("test reset and flags done");
    // force mode breaks at a boundary on a full match
    i_debug_active = 1'b1;
    h.wr(8'h04, 8'h18);
    {i_debug_active, i_cpu_addr, i_insn_boundary} = {1'b0, ~bd, 1'b1};
    cy(3);
    n_brk = 0;
    i_cpu_addr = bd;
    cy(3);
    chk("force break", 1'b1, n_brk > 0);
    i_cpu_addr = ~bd;
    cy(3);
    i_debug_active = 1'b1;
    h.wr(8'h04, 8'h08);
    {i_debug_active, i_cpu_addr, n_brk} = {1'b0, bd, 32'h0};
    cy(4);
    chk("disabled", 16'h0000, 16'(n_brk));
    // tag mode: tag on fetch, break only when the opcode executes
    i_debug_active = 1'b1;
    h.wr(8'h04, 8'h10);
    {i_debug_active, i_insn_boundary, i_cpu_fetch, n_brk, n_tag} = {3'b001, 64'h0};
    cy(1);
    {i_cpu_fetch, i_cpu_addr} = {1'b0, ~bd};
    cy(2);
    chk("tag", 16'h0001, 16'(n_tag));
    i_cpu_exec_tagged = 1'b1;
    cy(1);
    i_cpu_exec_tagged = 1'b0;
    cy(2);
    chk("tag break", 16'h0001, 16'(n_brk));
    $display("test breakpoint done");
    test_done();
  end
endmodule
